// >>> dma_zero_a_pkg.sv
// Constants, field layout and state encoding for the channel zero A transfer engine
//
// Notes on behaviour
// - Short mode: trigger field picks timer 0/1/2, A/D end, serial tx-empty or rx-full.
// - Trigger codes 110 and 111 switch the channel into full address mode.
// - End interrupt enable passes or suppresses the transfer-end interrupt request.
// - Transfers run only while the go bit is set; cleared go stops them.
// - Short mode: memory pointer steps by 1 or 2, up or down per direction.
// - Full mode: source pointer fixed unless step enable; then steps 1 or 2.
// - Short I/O and idle modes use the whole 16-bit count as counter.
// - Repeat mode: count high byte is an 8-bit transfer counter.
// - Repeat mode: count low byte holds the initial count for restarts.
// - Full normal mode: the whole 16-bit count is one transfer counter.
// - Full block mode: high byte counts block size, low byte restarts it.
// - I/O pointer gives peripheral address in short mode, ignored in full mode.
////////////////////////////////////////////////////////////////////////////////
`default_nettype none
package dma_zero_a_pkg;
    // Register indices, byte address is four times the index
    localparam logic [19:0] IDX_MEM_PTR = 20'hfff20;
    localparam logic [19:0] IDX_COUNT = 20'hfff24;
    localparam logic [19:0] IDX_IO_PTR = 20'hfff26;
    localparam logic [19:0] IDX_CTRL = 20'hfff27;
    localparam logic [19:0] IDX_B_PTR = 20'hfff28;
    localparam logic [19:0] IDX_IRQ_STAT = 20'hfff40;
    localparam logic [19:0] IDX_IRQ_MASK = 20'hfff41;
    localparam logic [19:0] IDX_AUX = 20'hfff42;
    // Control register field positions
    localparam int GO_BIT = 7;
    localparam int SIZE_BIT = 6;
    localparam int DIR_BIT = 5;
    localparam int RELOAD_BIT = 4;
    localparam int STEP_EN_BIT = 4;
    localparam int IE_BIT = 3;
    localparam int SEL_BIT2 = 2;
    localparam int SEL_BIT1 = 1;
    localparam int SEL_BIT0 = 0;
    localparam int BLOCK_BIT = 0;
    // Interrupt status layout
    localparam int STAT_END = 0;
    localparam int STAT_RELOAD = 1;
    localparam int STAT_W = 2;
    // Trigger sources in short mode
    localparam int TRIG_N = 6;
    localparam logic [2:0] TRIG_AD_END = 3'h3;
    localparam logic [2:0] TRIG_RX_FULL = 3'h5;
    // Values after reset
    localparam logic [31:0] PTR_RST = 32'h0;
    localparam logic [15:0] CNT_RST = 16'h0;
    localparam logic [7:0] IO_RST = 8'h0;
    localparam logic [7:0] CTRL_RST = 8'h0;
    localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
    // Transfer sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_REQ = 3'b010,
        ST_UPD = 3'b100
    } xfer_state_e;
endpackage : dma_zero_a_pkg
`default_nettype wire

// >>> xfer_update.sv
// Pointer stepping and count arithmetic after one transfer
`timescale 1ns/1ps
`default_nettype none
module xfer_update
    import dma_zero_a_pkg::*;
(
    input wire logic [31:0] mem_ptr,
    input wire logic [15:0] count,
    input wire logic word,
    input wire logic down,
    input wire logic step_en,
    input wire logic reload8,
    output logic [31:0] mem_ptr_nxt,
    output logic [15:0] count_nxt,
    output logic zero
);
    logic [31:0] step;
    logic [7:0] hi_dec;
    logic [15:0] full_dec;

    // Step of one byte or one word
    assign step = word ? 32'h2 : 32'h1;

    // Pointer moves up, down or stays
    always_comb begin
        if (!step_en) begin
            mem_ptr_nxt = mem_ptr;
        end else if (down) begin
            mem_ptr_nxt = mem_ptr - step;
        end else begin
            mem_ptr_nxt = mem_ptr + step;
        end
    end

    // Counter decrement, 8-bit with restart or 16-bit
    assign hi_dec = count[15:8] - 8'h1;
    assign full_dec = count - 16'h1;
    always_comb begin
        if (reload8) begin
            zero = (hi_dec == 8'h0);
            count_nxt = zero ? {count[7:0], count[7:0]} : {hi_dec, count[7:0]};
        end else begin
            zero = (full_dec == 16'h0);
            count_nxt = full_dec;
        end
    end
endmodule : xfer_update
`default_nettype wire

// >>> dma_channel_zero_a.sv
// Channel zero A transfer engine with Avalon-MM register slave
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_zero_a
    import dma_zero_a_pkg::*;
#(
    parameter int ADDR_W = 24
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [TRIG_N-1:0] trig_req,
    input wire logic full_req,
    output logic xfer_valid,
    input wire logic xfer_done,
    output logic [31:0] xfer_mem_addr,
    output logic [31:0] xfer_dst_addr,
    output logic [7:0] xfer_io_addr,
    output logic xfer_word,
    output logic xfer_to_io,
    output logic xfer_full,
    output logic irq
);
    // Byte address must reach the highest index
    if (ADDR_W < 22 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must lie between 22 and 32");
    end

    logic [31:0] mem_ptr_r;
    logic [15:0] count_r;
    logic [7:0] io_ptr_r;
    logic [7:0] ctrl_r;
    logic [31:0] b_ptr_r;
    logic [STAT_W-1:0] stat_r;
    logic [STAT_W-1:0] mask_r;
    logic block_r;
    logic ack_r;
    logic [31:0] rdata_r;
    xfer_state_e state_r;
    logic pend_r;
    logic word_r;
    logic to_io_r;
    logic full_r;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus decode
    ////////////////////////////////////////////////////////////////////////////
    logic [ADDR_W-3:0] widx;
    logic aligned;
    logic hit_mem, hit_cnt, hit_io, hit_ctl, hit_b, hit_stat, hit_mask, hit_aux;
    logic wr_acc, rd_acc;
    logic wr_mem, wr_cnt, wr_io, wr_ctl, wr_b;
    logic [31:0] mrg_mem, mrg_cnt, mrg_io, mrg_ctl, mrg_b;
    logic [31:0] rd_val;

    // Apply byte enables to an old word
    function automatic logic [31:0] be_merge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // Word index and register hits
    assign widx = avs_address[ADDR_W-1:2];
    assign aligned = (avs_address[1:0] == 2'h0);
    assign hit_mem = aligned && (widx == (ADDR_W-2)'(IDX_MEM_PTR));
    assign hit_cnt = aligned && (widx == (ADDR_W-2)'(IDX_COUNT));
    assign hit_io = aligned && (widx == (ADDR_W-2)'(IDX_IO_PTR));
    assign hit_ctl = aligned && (widx == (ADDR_W-2)'(IDX_CTRL));
    assign hit_b = aligned && (widx == (ADDR_W-2)'(IDX_B_PTR));
    assign hit_stat = aligned && (widx == (ADDR_W-2)'(IDX_IRQ_STAT));
    assign hit_mask = aligned && (widx == (ADDR_W-2)'(IDX_IRQ_MASK));
    assign hit_aux = aligned && (widx == (ADDR_W-2)'(IDX_AUX));

    // One wait cycle, then the access is taken
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign wr_acc = ack_r && avs_write;
    assign rd_acc = ack_r && avs_read;
    assign wr_mem = wr_acc && hit_mem;
    assign wr_cnt = wr_acc && hit_cnt;
    assign wr_io = wr_acc && hit_io;
    assign wr_ctl = wr_acc && hit_ctl;
    assign wr_b = wr_acc && hit_b;
    assign mrg_mem = be_merge(mem_ptr_r, avs_writedata, avs_byteenable);
    assign mrg_cnt = be_merge({16'h0, count_r}, avs_writedata, avs_byteenable);
    assign mrg_io = be_merge({24'h0, io_ptr_r}, avs_writedata, avs_byteenable);
    assign mrg_ctl = be_merge({24'h0, ctrl_r}, avs_writedata, avs_byteenable);
    assign mrg_b = be_merge(b_ptr_r, avs_writedata, avs_byteenable);

    // Access handshake flop
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    // Read multiplexer, unmapped reads give zero
    always_comb begin
        rd_val = 32'h0;
        if (hit_mem) rd_val = mem_ptr_r;
        if (hit_cnt) rd_val = {16'h0, count_r};
        if (hit_io) rd_val = {24'h0, io_ptr_r};
        if (hit_ctl) rd_val = {24'h0, ctrl_r};
        if (hit_b) rd_val = b_ptr_r;
        if (hit_stat) rd_val = {{(32-STAT_W){1'b0}}, stat_r};
        if (hit_mask) rd_val = {{(32-STAT_W){1'b0}}, mask_r};
        if (hit_aux) rd_val = {31'h0, block_r};
    end

    // Read data captured in the wait cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_r <= 32'h0;
        end else if (avs_read && !ack_r) begin
            rdata_r <= rd_val;
        end
    end
    assign avs_readdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode and trigger selection
    ////////////////////////////////////////////////////////////////////////////
    logic go, ie, full_mode, repeat_mode, block_mode, reload8, step_en;
    logic [2:0] sel;
    logic trig_hit, start, upd;
    logic [31:0] mem_nxt;
    logic [15:0] cnt_nxt;
    logic cnt_zero, end_evt, reload_evt;

    assign go = ctrl_r[GO_BIT];
    assign ie = ctrl_r[IE_BIT];
    assign sel = {ctrl_r[SEL_BIT2], ctrl_r[SEL_BIT1], ctrl_r[SEL_BIT0]};
    assign full_mode = sel[2] && sel[1];
    assign repeat_mode = !full_mode && ctrl_r[RELOAD_BIT] && !ie;
    assign block_mode = full_mode && block_r;
    assign reload8 = repeat_mode || block_mode;
    assign step_en = full_mode ? ctrl_r[STEP_EN_BIT] : 1'b1;

    // Selected activation source
    always_comb begin
        if (full_mode) begin
            trig_hit = full_req;
        end else begin
            trig_hit = trig_req[sel];
        end
    end

    // Pending request, a new trigger wins over the clear
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pend_r <= 1'b0;
        end else if (!go) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= (go && trig_hit) || (pend_r && !start);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transfer sequencer
    ////////////////////////////////////////////////////////////////////////////
    assign start = (state_r == ST_IDLE) && go && pend_r;
    assign upd = (state_r == ST_UPD);
    assign end_evt = upd && cnt_zero && !repeat_mode;
    assign reload_evt = upd && cnt_zero && reload8;

    // Idle, request held until done, then update
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (start) state_r <= ST_REQ;
                end
                ST_REQ: begin
                    if (xfer_done) state_r <= ST_UPD;
                end
                ST_UPD: begin
                    // A block runs back to back until its size is used up
                    if (block_mode && !cnt_zero && go) begin
                        state_r <= ST_REQ;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Transfer attributes fixed for the request
    always_ff @(posedge clk) begin
        if (!resetn) begin
            word_r <= 1'b0;
            to_io_r <= 1'b0;
            full_r <= 1'b0;
        end else if (start) begin
            word_r <= ctrl_r[SIZE_BIT];
            to_io_r <= !full_mode && (sel != TRIG_AD_END) && (sel != TRIG_RX_FULL);
            full_r <= full_mode;
        end
    end

    assign xfer_valid = (state_r == ST_REQ);
    assign xfer_mem_addr = mem_ptr_r;
    assign xfer_dst_addr = b_ptr_r;
    assign xfer_io_addr = full_r ? 8'h0 : io_ptr_r;
    assign xfer_word = word_r;
    assign xfer_to_io = to_io_r;
    assign xfer_full = full_r;

    // Next pointer and count after one transfer
    xfer_update u_upd (
        .mem_ptr(mem_ptr_r),
        .count(count_r),
        .word(ctrl_r[SIZE_BIT]),
        .down(ctrl_r[DIR_BIT]),
        .step_en(step_en),
        .reload8(reload8),
        .mem_ptr_nxt(mem_nxt),
        .count_nxt(cnt_nxt),
        .zero(cnt_zero)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Channel registers, software writes win over hardware updates
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mem_ptr_r <= PTR_RST;
        end else if (wr_mem) begin
            mem_ptr_r <= mrg_mem;
        end else if (upd) begin
            mem_ptr_r <= mem_nxt;
        end
    end

    // Transfer count
    always_ff @(posedge clk) begin
        if (!resetn) begin
            count_r <= CNT_RST;
        end else if (wr_cnt) begin
            count_r <= mrg_cnt[15:0];
        end else if (upd) begin
            count_r <= cnt_nxt;
        end
    end

    // Peripheral pointer and far pointer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            io_ptr_r <= IO_RST;
            b_ptr_r <= PTR_RST;
        end else begin
            if (wr_io) io_ptr_r <= mrg_io[7:0];
            if (wr_b) b_ptr_r <= mrg_b;
        end
    end

    // Control, go cleared by hardware at the end of a run
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_ctl) begin
            ctrl_r <= mrg_ctl[7:0];
        end else if (end_evt) begin
            ctrl_r[GO_BIT] <= 1'b0;
        end
    end

    // Block mode select
    always_ff @(posedge clk) begin
        if (!resetn) begin
            block_r <= 1'b0;
        end else if (wr_acc && hit_aux && avs_byteenable[0]) begin
            block_r <= avs_writedata[BLOCK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask
    ////////////////////////////////////////////////////////////////////////////
    logic [STAT_W-1:0] stat_set;

    assign stat_set[STAT_END] = end_evt && ie;
    assign stat_set[STAT_RELOAD] = reload_evt;

    // Sticky status, a read clears only the bits it returned, a new event wins
    always_ff @(posedge clk) begin
        if (!resetn) begin
            stat_r <= STAT_RST;
        end else if (rd_acc && hit_stat) begin
            stat_r <= (stat_r & ~rdata_r[STAT_W-1:0]) | stat_set;
        end else begin
            stat_r <= stat_r | stat_set;
        end
    end

    // Mask register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mask_r <= STAT_RST;
        end else if (wr_acc && hit_mask && avs_byteenable[0]) begin
            mask_r <= avs_writedata[STAT_W-1:0];
        end
    end

    assign irq = |(stat_r & mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////////////
    sequence s_quiet_upd;
        upd && !wr_mem && !wr_cnt && !wr_ctl;
    endsequence

    sequence s_trig_start;
        (state_r == ST_IDLE) && go && !pend_r && trig_hit && !wr_ctl ##1 pend_r;
    endsequence

    property p_trig_sel;
        @(posedge clk) disable iff (!resetn)
        (state_r == ST_IDLE) && go && !full_mode && trig_req[sel] && !pend_r && !wr_ctl
        |=> pend_r ##1 xfer_valid;
    endproperty
    a_trig_sel: assert property (p_trig_sel) else $error("selected trigger did not start a transfer");

    property p_full_flag;
        @(posedge clk) disable iff (!resetn)
        s_trig_start |=> xfer_valid && (xfer_full == $past(full_mode, 2));
    endproperty
    a_full_flag: assert property (p_full_flag) else $error("full mode flag wrong on request");

    property p_end_irq;
        @(posedge clk) disable iff (!resetn)
        end_evt |=> (stat_r[STAT_END] == ($past(ie) || $past(stat_r[STAT_END])
            && !$past(rd_acc && hit_stat && rdata_r[STAT_END])));
    endproperty
    a_end_irq: assert property (p_end_irq) else $error("end status not gated by enable");

    property p_no_go;
        @(posedge clk) disable iff (!resetn)
        (state_r == ST_IDLE) && !go |=> !xfer_valid;
    endproperty
    a_no_go: assert property (p_no_go) else $error("transfer started with go clear");

    property p_short_step;
        @(posedge clk) disable iff (!resetn)
        s_quiet_upd and (!full_mode) |=>
        mem_ptr_r == ($past(ctrl_r[DIR_BIT]) ? $past(mem_ptr_r) - ($past(ctrl_r[SIZE_BIT]) ? 32'h2 : 32'h1)
                                             : $past(mem_ptr_r) + ($past(ctrl_r[SIZE_BIT]) ? 32'h2 : 32'h1));
    endproperty
    a_short_step: assert property (p_short_step) else $error("short mode pointer step wrong");

    property p_full_fixed;
        @(posedge clk) disable iff (!resetn)
        s_quiet_upd and (full_mode && !ctrl_r[STEP_EN_BIT]) |=> $stable(mem_ptr_r);
    endproperty
    a_full_fixed: assert property (p_full_fixed) else $error("fixed source pointer moved");

    property p_count16;
        @(posedge clk) disable iff (!resetn)
        s_quiet_upd and (!reload8) |=> count_r == $past(count_r) - 16'h1;
    endproperty
    a_count16: assert property (p_count16) else $error("16-bit counter did not decrement");

    property p_count8;
        @(posedge clk) disable iff (!resetn)
        s_quiet_upd and (reload8 && count_r[15:8] != 8'h1) |=>
        count_r[15:8] == $past(count_r[15:8]) - 8'h1 && $stable(count_r[7:0]);
    endproperty
    a_count8: assert property (p_count8) else $error("8-bit counter step wrong");

    property p_restart;
        @(posedge clk) disable iff (!resetn)
        s_quiet_upd and (reload8 && count_r[15:8] == 8'h1) |=> count_r[15:8] == $past(count_r[7:0]);
    endproperty
    a_restart: assert property (p_restart) else $error("counter not restarted from initial count");

    property p_io_addr;
        @(posedge clk) disable iff (!resetn)
        $rose(xfer_valid) |-> (xfer_io_addr == (xfer_full ? 8'h0 : io_ptr_r));
    endproperty
    a_io_addr: assert property (p_io_addr) else $error("peripheral address wrong");

    property p_end_stop;
        @(posedge clk) disable iff (!resetn)
        end_evt && !wr_ctl |=> !go ##1 (state_r == ST_IDLE) [*2];
    endproperty
    a_end_stop: assert property (p_end_stop) else $error("channel kept running after end");

    property p_bus_wait;
        @(posedge clk) disable iff (!resetn)
        (avs_read || avs_write) && !ack_r |-> avs_waitrequest ##1 (!avs_waitrequest || !(avs_read || avs_write));
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus answer not in one wait cycle");
endmodule : dma_channel_zero_a
`default_nettype wire

// >>> xfer_responder.sv
// Far-side bus model answering transfer requests after a set latency
`timescale 1ns/1ps
`default_nettype none
module xfer_responder (
    input wire logic clk,
    input wire logic resetn,
    input wire logic xfer_valid,
    input wire logic [3:0] latency,
    output logic xfer_done
);
    logic [3:0] wait_r;
    logic done_r;
    // One-cycle done pulse after latency plus one cycles of valid
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wait_r <= 4'h0;
            done_r <= 1'b0;
        end else if (xfer_valid && !done_r && wait_r == latency) begin
            wait_r <= 4'h0;
            done_r <= 1'b1;
        end else if (xfer_valid && !done_r) begin
            wait_r <= wait_r + 4'h1;
        end else begin
            done_r <= 1'b0;
        end
    end
    assign xfer_done = done_r;
endmodule : xfer_responder
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the channel zero A transfer engine
`timescale 1ns/1ps
`default_nettype none
module testbench
    import dma_zero_a_pkg::*;
;
    logic clk, resetn, avs_read, avs_write, avs_waitrequest;
    logic [23:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, xfer_mem_addr, xfer_dst_addr;
    logic [3:0] avs_byteenable, latency;
    logic [TRIG_N-1:0] trig_req;
    logic full_req, xfer_valid, xfer_done, xfer_word, xfer_to_io, xfer_full, irq;
    logic [7:0] xfer_io_addr;
    logic [19:0] regs [8] = '{IDX_MEM_PTR, IDX_COUNT, IDX_IO_PTR, IDX_CTRL, IDX_B_PTR, IDX_IRQ_STAT, IDX_IRQ_MASK,
        20'hfff30};
    int n_errors, tests_run, done_cnt;

    dma_channel_zero_a #(.ADDR_W(24)) dma_channel_zero_a_i (.clk(clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .trig_req(trig_req), .full_req(full_req), .xfer_valid(xfer_valid), .xfer_done(xfer_done),
        .xfer_mem_addr(xfer_mem_addr), .xfer_dst_addr(xfer_dst_addr), .xfer_io_addr(xfer_io_addr),
        .xfer_word(xfer_word), .xfer_to_io(xfer_to_io), .xfer_full(xfer_full), .irq(irq));
    xfer_responder xfer_responder_i (.clk(clk), .resetn(resetn), .xfer_valid(xfer_valid), .latency(latency),
        .xfer_done(xfer_done));

    // Clock, transfer counter and watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (xfer_valid === 1'b1 && xfer_done === 1'b1) done_cnt++;
    initial begin
        #100000;
        n_errors++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bchk(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : bchk
    // One bus cycle, held until waitrequest is seen low
    task automatic acc(input logic wr, input logic [19:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        avs_address <= {2'b00, idx, 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= wd;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) begin
            n_errors++;
            final_report();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : acc
    task automatic rchk(input string what, input logic [19:0] idx, input logic [31:0] exp);
        acc(1'b0, idx, 32'h0);
        chk(what, exp, rd);
    endtask : rchk
    task automatic setup(input logic [31:0] ptr, input logic [15:0] cnt, input logic [7:0] ctl);
        acc(1'b1, IDX_MEM_PTR, ptr);
        acc(1'b1, IDX_COUNT, {16'h0, cnt});
        acc(1'b1, IDX_CTRL, {24'h0, ctl});
    endtask : setup
    // Pulse a source (6 = full mode request) and count finished transfers
    task automatic fire(input int src, input int expect_n);
        int start, n;
        start = done_cnt;
        n = 0;
        if (src == 6) full_req <= 1'b1;
        else trig_req <= 6'h01 << src;
        @(posedge clk);
        full_req <= 1'b0;
        trig_req <= '0;
        while (done_cnt < start + expect_n && n < 100) begin
            @(posedge clk);
            n++;
        end
        repeat (8) @(posedge clk);
        chk("transfers", expect_n, done_cnt - start);
    endtask : fire
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hf;
        trig_req = '0;
        full_req = 1'b0;
        latency = 4'h0;
        n_errors = 0;
        tests_run = 0;
        done_cnt = 0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        // Reset values and unmapped word
        foreach (regs[i]) rchk("reset value", regs[i], 32'h0);
        acc(1'b1, 20'hfff30, 32'hffffffff);
        rchk("unmapped", 20'hfff30, 32'h0);
        acc(1'b1, IDX_IRQ_MASK, 32'h3);
        acc(1'b1, IDX_IO_PTR, 32'h5a);
        acc(1'b1, IDX_B_PTR, 32'h9000);
        // Short byte upward run with end interrupt
        setup(32'h1000, 16'h2, 8'h88);
        fire(0, 1);
        chk("pointer", 32'h1001, xfer_mem_addr);
        chk("io addr", 32'h5a, {24'h0, xfer_io_addr});
        rchk("count", IDX_COUNT, 32'h1);
        bchk("irq", 1'b0, irq);
        fire(0, 1);
        chk("pointer", 32'h1002, xfer_mem_addr);
        rchk("control", IDX_CTRL, 32'h08);
        bchk("irq", 1'b1, irq);
        rchk("status", IDX_IRQ_STAT, 32'h1);
        bchk("irq", 1'b0, irq);
        fire(0, 0);
        // Every short-mode source, word downward, interrupt off
        latency <= 4'h3;
        for (int c = 0; c < 6; c++) begin
            setup(32'h2000, 16'h1, {5'h1c, 3'(c)});
            fire((c + 1) % 6, 0);
            fire(c, 1);
            chk("pointer", 32'h1ffe, xfer_mem_addr);
            bchk("word", 1'b1, xfer_word);
            bchk("to io", c != 3 && c != 5, xfer_to_io);
            rchk("control", IDX_CTRL, {24'h0, 5'h0c, 3'(c)});
        end
        rchk("status", IDX_IRQ_STAT, 32'h0);
        // Repeat mode restarts the high byte from the low byte
        setup(32'h3000, 16'h0202, 8'h90);
        fire(0, 1);
        rchk("count", IDX_COUNT, 32'h0102);
        fire(0, 1);
        rchk("count", IDX_COUNT, 32'h0202);
        rchk("control", IDX_CTRL, 32'h90);
        chk("pointer", 32'h3002, xfer_mem_addr);
        acc(1'b1, IDX_IRQ_MASK, 32'h0);
        bchk("masked irq", 1'b0, irq);
        acc(1'b1, IDX_IRQ_MASK, 32'h3);
        bchk("irq", 1'b1, irq);
        rchk("status", IDX_IRQ_STAT, 32'h2);
        // Idle mode keeps the whole 16-bit counter
        setup(32'h3000, 16'h0101, 8'h98);
        fire(0, 1);
        rchk("count", IDX_COUNT, 32'h0100);
        rchk("control", IDX_CTRL, 32'h98);
        // Full address mode, slow far side
        latency <= 4'h5;
        setup(32'h4000, 16'h2, 8'he6);
        fire(0, 0);
        fire(6, 1);
        bchk("full", 1'b1, xfer_full);
        chk("io addr", 32'h0, {24'h0, xfer_io_addr});
        chk("dest", 32'h9000, xfer_dst_addr);
        fire(6, 1);
        chk("pointer", 32'h4000, xfer_mem_addr);
        rchk("control", IDX_CTRL, 32'h66);
        setup(32'h4000, 16'h1, 8'hf7);
        fire(6, 1);
        chk("pointer", 32'h3ffe, xfer_mem_addr);
        setup(32'h4000, 16'h1, 8'h96);
        fire(6, 1);
        chk("pointer", 32'h4001, xfer_mem_addr);
        // Block transfer runs one whole block per request
        acc(1'b1, IDX_AUX, 32'h1);
        setup(32'h5000, 16'h0202, 8'h96);
        fire(6, 2);
        chk("pointer", 32'h5002, xfer_mem_addr);
        rchk("count", IDX_COUNT, 32'h0202);
        rchk("control", IDX_CTRL, 32'h16);
        final_report();
    end
endmodule : testbench
`default_nettype wire
